// >>> shared/snts_pkg.sv
// shared constants and types for the two-wire byte memory slave and its master
package snts_pkg;
    // memory geometry
    localparam int MEM_DEPTH = 8192;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 13;
    // device-type field of the first byte; value is arbitrary, not a real part code
    localparam logic [3:0] DEV_TYPE = 4'h6;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    // bit slots inside one byte frame: 8 data slots then the acknowledge slot
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] BYTE_DONE = 4'h9;
    // synchroniser reset levels: idle bus lines sit high
    localparam logic LINE_IDLE = 1'b1;
    // master timing: one quarter of an scl period, least time, rounded up
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCL_QTR_NS = 250;
    localparam int SCL_QTR_CYC = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // master byte sequence indices
    localparam logic [2:0] IDX_DEV_W = 3'h0;
    localparam logic [2:0] IDX_ADDR_HI = 3'h1;
    localparam logic [2:0] IDX_ADDR_LO = 3'h2;
    localparam logic [2:0] IDX_THIRD = 3'h3;
    localparam logic [2:0] IDX_READ = 3'h4;

    typedef enum logic [2:0] {
        SNTS_D_IDLE,
        SNTS_D_DEV,
        SNTS_D_AHI,
        SNTS_D_ALO,
        SNTS_D_WDATA,
        SNTS_D_RDATA
    } snts_dev_state_t;

    typedef enum logic [1:0] {
        SNTS_M_IDLE,
        SNTS_M_START,
        SNTS_M_BIT,
        SNTS_M_STOP
    } snts_mst_state_t;
endpackage : snts_pkg

// >>> shared/snts_bus_if.sv
// two-wire bus carrier: open-drain resolution of scl and sda between master and slave
`timescale 1ns/1ps
interface snts_bus_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic scl;
    logic sda;

    // pull-ups hold a released line high; any enabled low driver wins
    assign scl = !(m_scl_oe && !m_scl_o);
    assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));

    modport mst (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe, input sda);
    modport dev (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface : snts_bus_if

// >>> rtl/snts_sync.sv
// three-stage pin synchroniser with agreement filter on the last two stages
`timescale 1ns/1ps
module snts_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_nxt;

    // a bit only moves once the second and third stages agree
    always_comb begin
        q_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & q_o);
    end

    // s1_r is read by s2_r alone
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_r <= RST;
            s2_r <= RST;
            s3_r <= RST;
            q_o <= RST;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_o <= q_nxt;
        end
    end
endmodule : snts_sync

// >>> rtl/snts_slave_end.sv
// two-wire byte memory slave end, clocked by the link sampling clock
`timescale 1ns/1ps
module snts_slave_end #(
    parameter int DEPTH = snts_pkg::MEM_DEPTH
) (
    input wire logic link_clk_i,
    input wire logic rst_b_i,
    snts_bus_if.dev bus,
    input wire logic chip_select_strap_bit0_i,
    input wire logic chip_select_strap_bit1_i,
    input wire logic chip_select_strap_bit2_i,
    input wire logic write_lock_i,
    output logic xfer_active_o,
    output logic wr_commit_o,
    output logic wr_refused_o
);
    import snts_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [BYTE_W-1:0] mem [DEPTH];
    logic scl_s;
    logic sda_s;
    logic [2:0] strap_s;
    logic lock_s;
    logic scl_q_r;
    logic sda_q_r;
    logic rise;
    logic fall;
    logic start_seen;
    logic stop_seen;
    snts_dev_state_t st_r;
    snts_dev_state_t st_nxt;
    logic [3:0] bitcnt_r;
    logic [3:0] bitcnt_nxt;
    logic [BYTE_W-1:0] shreg_r;
    logic [BYTE_W-1:0] shreg_nxt;
    logic [BYTE_W-1:0] addr_hi_r;
    logic [BYTE_W-1:0] addr_hi_nxt;
    logic [AW-1:0] addr_r;
    logic [AW-1:0] addr_nxt;
    logic [AW-1:0] addr_inc;
    logic sda_oe_r;
    logic sda_oe_nxt;
    logic mack_r;
    logic mack_nxt;
    logic active_nxt;
    logic commit_nxt;
    logic refused_nxt;
    logic mem_we;
    logic [BYTE_W-1:0] next_byte;

    // wrapping increment, last location rolls to zero
    function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a);
        next_addr = (a == AW'(DEPTH - 1)) ? '0 : a + AW'(1);
    endfunction : next_addr

    // straps and lock are pins too; the synchroniser reset loads them low
    snts_sync #(
        .W(6),
        .RST({LINE_IDLE, LINE_IDLE, 4'h0})
    ) u_sync (
        .clk_i(link_clk_i),
        .rst_b_i(rst_b_i),
        .d_i({bus.scl, bus.sda, chip_select_strap_bit2_i, chip_select_strap_bit1_i,
              chip_select_strap_bit0_i, write_lock_i}),
        .q_o({scl_s, sda_s, strap_s, lock_s})
    );

    // edges only on the filtered copies, so a glitch cannot fake a start
    always_comb begin
        rise = scl_s && !scl_q_r;
        fall = !scl_s && scl_q_r;
        start_seen = scl_s && scl_q_r && sda_q_r && !sda_s;
        stop_seen = scl_s && scl_q_r && !sda_q_r && sda_s;
    end

    // open drain: the data level is always low, only the enable moves
    assign bus.d_sda_o = 1'b0;
    assign bus.d_sda_oe = sda_oe_r;

    assign addr_inc = next_addr(addr_r);
    assign next_byte = mem[addr_inc];

    // protocol engine; bitcnt counts scl rises within the current byte frame
    always_comb begin
        st_nxt = st_r;
        bitcnt_nxt = bitcnt_r;
        shreg_nxt = shreg_r;
        addr_hi_nxt = addr_hi_r;
        addr_nxt = addr_r;
        sda_oe_nxt = sda_oe_r;
        mack_nxt = mack_r;
        commit_nxt = 1'b0;
        refused_nxt = 1'b0;
        mem_we = 1'b0;
        if (start_seen) begin
            st_nxt = SNTS_D_DEV;
            bitcnt_nxt = '0;
            sda_oe_nxt = 1'b0;
        end else if (stop_seen) begin
            // no write timer exists, so standby is reached at once
            st_nxt = SNTS_D_IDLE;
            sda_oe_nxt = 1'b0;
        end else if (st_r != SNTS_D_IDLE) begin
            if (rise) begin
                if (bitcnt_r < ACK_SLOT && st_r != SNTS_D_RDATA) begin
                    shreg_nxt = {shreg_r[BYTE_W-2:0], sda_s};
                end
                if (bitcnt_r == ACK_SLOT && st_r == SNTS_D_RDATA) begin
                    mack_nxt = sda_s; // high means the master declined
                end
                if (bitcnt_r < BYTE_DONE) begin
                    bitcnt_nxt = bitcnt_r + 4'h1;
                end
            end else if (fall) begin
                if (bitcnt_r == ACK_SLOT) begin
                    if (st_r == SNTS_D_RDATA) begin
                        sda_oe_nxt = 1'b0;
                    end else if (st_r == SNTS_D_DEV &&
                                 (shreg_r[7:4] != DEV_TYPE || shreg_r[3:1] != strap_s)) begin
                        st_nxt = SNTS_D_IDLE;
                        sda_oe_nxt = 1'b0;
                    end else begin
                        sda_oe_nxt = 1'b1;
                    end
                end else if (bitcnt_r == BYTE_DONE) begin
                    bitcnt_nxt = '0;
                    sda_oe_nxt = 1'b0;
                    case (st_r)
                        SNTS_D_DEV: begin
                            if (shreg_r[0] == DIR_READ) begin
                                st_nxt = SNTS_D_RDATA;
                                shreg_nxt = mem[addr_r];
                                sda_oe_nxt = !mem[addr_r][BYTE_W-1];
                            end else begin
                                st_nxt = SNTS_D_AHI;
                            end
                        end
                        SNTS_D_AHI: begin
                            addr_hi_nxt = shreg_r;
                            st_nxt = SNTS_D_ALO;
                        end
                        SNTS_D_ALO: begin
                            addr_nxt = AW'({addr_hi_r, shreg_r});
                            st_nxt = SNTS_D_WDATA;
                        end
                        SNTS_D_WDATA: begin
                            // locked bytes are still acknowledged but never stored
                            if (lock_s) begin
                                refused_nxt = 1'b1;
                            end else begin
                                mem_we = 1'b1;
                                commit_nxt = 1'b1;
                            end
                            addr_nxt = addr_inc;
                        end
                        SNTS_D_RDATA: begin
                            addr_nxt = addr_inc;
                            if (mack_r) begin
                                st_nxt = SNTS_D_IDLE;
                            end else begin
                                shreg_nxt = next_byte;
                                sda_oe_nxt = !next_byte[BYTE_W-1];
                            end
                        end
                        default: begin
                            st_nxt = SNTS_D_IDLE;
                        end
                    endcase
                end else if (st_r == SNTS_D_RDATA) begin
                    // next data bit goes out just after scl falls
                    sda_oe_nxt = !shreg_r[BYTE_W-2];
                    shreg_nxt = {shreg_r[BYTE_W-2:0], 1'b0};
                end else begin
                    sda_oe_nxt = 1'b0;
                end
            end
        end
        active_nxt = (st_nxt != SNTS_D_IDLE);
    end

    // state registers
    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= SNTS_D_IDLE;
            bitcnt_r <= '0;
            shreg_r <= '0;
            addr_hi_r <= '0;
            addr_r <= '0;
            sda_oe_r <= 1'b0;
            mack_r <= 1'b0;
            scl_q_r <= LINE_IDLE;
            sda_q_r <= LINE_IDLE;
            xfer_active_o <= 1'b0;
            wr_commit_o <= 1'b0;
            wr_refused_o <= 1'b0;
        end else begin
            st_r <= st_nxt;
            bitcnt_r <= bitcnt_nxt;
            shreg_r <= shreg_nxt;
            addr_hi_r <= addr_hi_nxt;
            addr_r <= addr_nxt;
            sda_oe_r <= sda_oe_nxt;
            mack_r <= mack_nxt;
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
            xfer_active_o <= active_nxt;
            wr_commit_o <= commit_nxt;
            wr_refused_o <= refused_nxt;
        end
    end

    // array keeps no reset: contents are meant to survive
    always_ff @(posedge link_clk_i) begin
        if (mem_we) begin
            mem[addr_r] <= shreg_r;
        end
    end
endmodule : snts_slave_end

// >>> rtl/snts_master_end.sv
// two-wire bus master end: scl from a divider, byte write and random read
`timescale 1ns/1ps
module snts_master_end #(
    parameter int QTR_CYC = snts_pkg::SCL_QTR_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    snts_bus_if.mst bus,
    input wire logic req_valid_i,
    input wire logic req_rnw_i,
    input wire logic [2:0] req_chip_i,
    input wire logic [snts_pkg::ADDR_W-1:0] req_addr_i,
    input wire logic [snts_pkg::BYTE_W-1:0] req_wdata_i,
    output logic req_ready_o,
    output logic done_o,
    output logic nack_o,
    output logic [snts_pkg::BYTE_W-1:0] rdata_o
);
    import snts_pkg::*;

    localparam int QW = $clog2(QTR_CYC + 1);

    snts_mst_state_t st_r;
    snts_mst_state_t st_nxt;
    logic [QW-1:0] qcnt_r;
    logic [QW-1:0] qcnt_nxt;
    logic [1:0] ph_r;
    logic [1:0] ph_nxt;
    logic [3:0] bitn_r;
    logic [3:0] bitn_nxt;
    logic [2:0] idx_r;
    logic [2:0] idx_nxt;
    logic rnw_r;
    logic rnw_nxt;
    logic [2:0] chip_r;
    logic [2:0] chip_nxt;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic [BYTE_W-1:0] wd_r;
    logic [BYTE_W-1:0] wd_nxt;
    logic [BYTE_W-1:0] sh_r;
    logic [BYTE_W-1:0] sh_nxt;
    logic scl_oe_r;
    logic scl_oe_nxt;
    logic sda_oe_r;
    logic sda_oe_nxt;
    logic ready_nxt;
    logic done_nxt;
    logic nack_nxt;
    logic [BYTE_W-1:0] rdata_nxt;
    logic tick;
    logic sda_s;
    logic [2:0] last_idx;

    // byte sent at each step of the sequence; a read byte is all released
    function automatic logic [BYTE_W-1:0] byte_for(input logic [2:0] i, input logic rnw,
                                                   input logic [2:0] chip,
                                                   input logic [ADDR_W-1:0] a,
                                                   input logic [BYTE_W-1:0] wd);
        case (i)
            IDX_DEV_W: byte_for = {DEV_TYPE, chip, DIR_WRITE};
            IDX_ADDR_HI: byte_for = BYTE_W'(a >> BYTE_W);
            IDX_ADDR_LO: byte_for = a[BYTE_W-1:0];
            IDX_THIRD: byte_for = rnw ? {DEV_TYPE, chip, DIR_READ} : wd;
            default: byte_for = '1;
        endcase
    endfunction : byte_for

    snts_sync #(
        .W(1),
        .RST(LINE_IDLE)
    ) u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i(bus.sda),
        .q_o(sda_s)
    );

    // open drain on both lines; this end alone makes scl
    assign bus.m_scl_o = 1'b0;
    assign bus.m_scl_oe = scl_oe_r;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_sda_oe = sda_oe_r;

    assign tick = (qcnt_r == QW'(QTR_CYC - 1));
    assign last_idx = rnw_r ? IDX_READ : IDX_THIRD;

    // quarter phases: 0 scl low, 1 sda moves, 2 scl high, 3 sample or mark
    always_comb begin
        st_nxt = st_r;
        qcnt_nxt = tick ? '0 : qcnt_r + QW'(1);
        ph_nxt = ph_r;
        bitn_nxt = bitn_r;
        idx_nxt = idx_r;
        rnw_nxt = rnw_r;
        chip_nxt = chip_r;
        addr_nxt = addr_r;
        wd_nxt = wd_r;
        sh_nxt = sh_r;
        scl_oe_nxt = scl_oe_r;
        sda_oe_nxt = sda_oe_r;
        ready_nxt = req_ready_o;
        done_nxt = 1'b0;
        nack_nxt = nack_o;
        rdata_nxt = rdata_o;
        case (st_r)
            SNTS_M_IDLE: begin
                qcnt_nxt = '0;
                ph_nxt = '0;
                if (req_valid_i && req_ready_o) begin
                    st_nxt = SNTS_M_START;
                    ready_nxt = 1'b0;
                    nack_nxt = 1'b0;
                    idx_nxt = IDX_DEV_W;
                    rnw_nxt = req_rnw_i;
                    chip_nxt = req_chip_i;
                    addr_nxt = req_addr_i;
                    wd_nxt = req_wdata_i;
                end
            end
            SNTS_M_START: begin
                if (tick) begin
                    ph_nxt = ph_r + 2'h1;
                    case (ph_r)
                        2'h0: scl_oe_nxt = 1'b1;
                        2'h1: sda_oe_nxt = 1'b0;
                        2'h2: scl_oe_nxt = 1'b0;
                        default: begin
                            sda_oe_nxt = 1'b1;
                            st_nxt = SNTS_M_BIT;
                            bitn_nxt = '0;
                            sh_nxt = byte_for(idx_r, rnw_r, chip_r, addr_r, wd_r);
                        end
                    endcase
                end
            end
            SNTS_M_BIT: begin
                if (tick) begin
                    ph_nxt = ph_r + 2'h1;
                    case (ph_r)
                        2'h0: scl_oe_nxt = 1'b1;
                        // data moves a quarter after scl falls, never near a high level
                        2'h1: sda_oe_nxt = (bitn_r < ACK_SLOT) ? !sh_r[BYTE_W-1] : 1'b0;
                        2'h2: scl_oe_nxt = 1'b0;
                        default: begin
                            bitn_nxt = bitn_r + 4'h1;
                            if (bitn_r < ACK_SLOT) begin
                                sh_nxt = {sh_r[BYTE_W-2:0], sda_s};
                            end else if (idx_r != IDX_READ && sda_s) begin
                                nack_nxt = 1'b1;
                                st_nxt = SNTS_M_STOP;
                            end else if (idx_r == last_idx) begin
                                rdata_nxt = rnw_r ? sh_r : rdata_o;
                                st_nxt = SNTS_M_STOP;
                            end else begin
                                idx_nxt = idx_r + 3'h1;
                                bitn_nxt = '0;
                                sh_nxt = byte_for(idx_r + 3'h1, rnw_r, chip_r, addr_r, wd_r);
                                if (rnw_r && idx_r == IDX_ADDR_LO) begin
                                    st_nxt = SNTS_M_START;
                                end
                            end
                        end
                    endcase
                end
            end
            SNTS_M_STOP: begin
                if (tick) begin
                    ph_nxt = ph_r + 2'h1;
                    case (ph_r)
                        2'h0: scl_oe_nxt = 1'b1;
                        2'h1: sda_oe_nxt = 1'b1;
                        2'h2: scl_oe_nxt = 1'b0;
                        default: begin
                            sda_oe_nxt = 1'b0;
                            st_nxt = SNTS_M_IDLE;
                            done_nxt = 1'b1;
                            ready_nxt = 1'b1;
                        end
                    endcase
                end
            end
            default: st_nxt = SNTS_M_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= SNTS_M_IDLE;
            qcnt_r <= '0;
            ph_r <= '0;
            bitn_r <= '0;
            idx_r <= '0;
            rnw_r <= 1'b0;
            chip_r <= '0;
            addr_r <= '0;
            wd_r <= '0;
            sh_r <= '0;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            req_ready_o <= 1'b1;
            done_o <= 1'b0;
            nack_o <= 1'b0;
            rdata_o <= '0;
        end else begin
            st_r <= st_nxt;
            qcnt_r <= qcnt_nxt;
            ph_r <= ph_nxt;
            bitn_r <= bitn_nxt;
            idx_r <= idx_nxt;
            rnw_r <= rnw_nxt;
            chip_r <= chip_nxt;
            addr_r <= addr_nxt;
            wd_r <= wd_nxt;
            sh_r <= sh_nxt;
            scl_oe_r <= scl_oe_nxt;
            sda_oe_r <= sda_oe_nxt;
            req_ready_o <= ready_nxt;
            done_o <= done_nxt;
            nack_o <= nack_nxt;
            rdata_o <= rdata_nxt;
        end
    end
endmodule : snts_master_end

// >>> verification/snts_sva.sv
// concurrent checks on the two-wire bus between the master and slave ends
`timescale 1ns/1ps
module snts_sva (
    input wire logic link_clk_i,
    input wire logic rst_b_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic d_sda_o,
    input wire logic d_sda_oe,
    input wire logic write_lock_i,
    input wire logic xfer_active_o,
    input wire logic wr_commit_o,
    input wire logic wr_refused_o
);
    default clocking cb @(posedge link_clk_i); endclocking
    default disable iff (!rst_b_i);
    // bus conditions on the resolved lines; sync latency is about four link cycles
    sequence s_start;
        scl && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $rose(sda);
    endsequence
    sequence s_idle2;
        !xfer_active_o ##1 !xfer_active_o;
    endsequence
    chk_sda_open_drain: assert property (d_sda_oe |-> !d_sda_o && xfer_active_o)
        else $error("slave drives sda high or outside a transfer");
    chk_dev_change_low: assert property ($changed(d_sda_oe) |-> !scl)
        else $error("slave moved sda while scl high");
    chk_start_seen: assert property (s_start |-> ##[1:8] xfer_active_o)
        else $error("start not taken");
    chk_stop_standby: assert property (s_stop |-> ##[1:8] !xfer_active_o)
        else $error("stop did not reach standby");
    chk_idle_released: assert property (s_idle2 |-> !d_sda_oe)
        else $error("standby slave holds sda");
    chk_lock_no_commit: assert property (wr_commit_o |-> !write_lock_i)
        else $error("byte stored while locked");
    chk_lock_drop: assert property (wr_refused_o |-> write_lock_i)
        else $error("byte dropped while unlocked");
    chk_commit_pulse: assert property (wr_commit_o |=> !wr_commit_o)
        else $error("commit pulse too long");
    cov_stop: cover property (s_stop);
endmodule : snts_sva

// >>> verification/snts_bench.sv
// bench: master end driving the slave end across the open-drain carrier
`timescale 1ns/1ps
module snts_bench;
    import snts_pkg::*;
    localparam int QTR = 10;
    localparam int LIMIT = 40000;
    localparam logic [2:0] STRAP = 3'h5;
    logic clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic req_rnw_i = 1'b0;
    logic [2:0] req_chip_i = 3'h0;
    logic [ADDR_W-1:0] req_addr_i = '0;
    logic [BYTE_W-1:0] req_wdata_i = '0;
    logic write_lock_i = 1'b0;
    logic [2:0] strap_i = STRAP;
    logic req_ready_o, done_o, nack_o, xfer_active_o, wr_commit_o, wr_refused_o;
    logic [BYTE_W-1:0] rdata_o;
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;
    int commits = 0;
    int refusals = 0;
    snts_bus_if bus_a ();
    snts_master_end #(.QTR_CYC(QTR)) u_snts_master_end (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .bus(bus_a.mst), .req_valid_i(req_valid_i), .req_rnw_i(req_rnw_i),
        .req_chip_i(req_chip_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .req_ready_o(req_ready_o), .done_o(done_o), .nack_o(nack_o), .rdata_o(rdata_o));
    snts_slave_end u_snts_slave_end (.link_clk_i(link_clk_i), .rst_b_i(rst_b_i),
        .bus(bus_a.dev), .chip_select_strap_bit0_i(strap_i[0]),
        .chip_select_strap_bit1_i(strap_i[1]), .chip_select_strap_bit2_i(strap_i[2]),
        .write_lock_i(write_lock_i), .xfer_active_o(xfer_active_o),
        .wr_commit_o(wr_commit_o), .wr_refused_o(wr_refused_o));
    snts_sva u_snts_sva (.link_clk_i(link_clk_i), .rst_b_i(rst_b_i), .scl(bus_a.scl),
        .sda(bus_a.sda), .d_sda_o(bus_a.d_sda_o), .d_sda_oe(bus_a.d_sda_oe),
        .write_lock_i(write_lock_i), .xfer_active_o(xfer_active_o),
        .wr_commit_o(wr_commit_o), .wr_refused_o(wr_refused_o));
    // system clock 20 ns
    always #10 clk_i = ~clk_i;
    // link clock 6 ns; its rising edges never meet a rising edge of clk_i
    always #3 link_clk_i = ~link_clk_i;
    // count slave pulses in their own domain
    always @(posedge link_clk_i) begin
        if (wr_commit_o === 1'b1) commits++;
        if (wr_refused_o === 1'b1) refusals++;
    end
    // hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one request, held for one clock, then wait for the done pulse
    task automatic do_req(input logic rnw, input logic [2:0] c, input logic [12:0] a,
                          input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_rnw_i <= rnw;
        req_chip_i <= c;
        req_addr_i <= a;
        req_wdata_i <= wd;
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        do begin
            @(negedge clk_i);
            n++;
        end while (done_o !== 1'b1 && n < 4000);
        if (n >= 4000) chk(8'hee, 8'h00);
        chk({7'h0, req_ready_o}, 8'h01);
    endtask : do_req
    // write then read back, back to back, at a low and the top address
    task automatic t_basic();
        int c0;
        c0 = commits;
        do_req(1'b0, STRAP, 13'h0123, 8'h5a);
        chk({7'h0, nack_o}, 8'h00);
        do_req(1'b0, STRAP, 13'h1fff, 8'hc3);
        do_req(1'b1, STRAP, 13'h0123, 8'h00);
        chk(rdata_o, 8'h5a);
        do_req(1'b1, STRAP, 13'h1fff, 8'h00);
        chk(rdata_o, 8'hc3);
        chk(8'(commits - c0), 8'h02);
        $display("test basic done");
    endtask : t_basic
    // every chip code: only the strap value answers
    task automatic t_chips();
        for (int c = 0; c < 8; c++) begin
            do_req(1'b1, 3'(c), 13'h0123, 8'h00);
            chk({7'h0, nack_o}, {7'h0, 3'(c) != STRAP});
        end
        // moved straps: the new code answers, the old one no longer does
        @(posedge clk_i);
        strap_i <= 3'h2;
        do_req(1'b1, 3'h2, 13'h0123, 8'h00);
        chk({7'h0, nack_o}, 8'h00);
        chk(rdata_o, 8'h5a);
        do_req(1'b1, STRAP, 13'h0123, 8'h00);
        chk({7'h0, nack_o}, 8'h01);
        @(posedge clk_i);
        strap_i <= STRAP;
        $display("test chips done");
    endtask : t_chips
    // locked write is dropped, reads still work
    task automatic t_lock();
        int r0;
        r0 = refusals;
        @(posedge clk_i);
        write_lock_i <= 1'b1;
        do_req(1'b0, STRAP, 13'h0123, 8'ha5);
        chk(8'(refusals - r0), 8'h01);
        do_req(1'b1, STRAP, 13'h0123, 8'h00);
        chk(rdata_o, 8'h5a);
        @(posedge clk_i);
        write_lock_i <= 1'b0;
        do_req(1'b0, STRAP, 13'h0123, 8'h3c);
        do_req(1'b1, STRAP, 13'h0123, 8'h00);
        chk(rdata_o, 8'h3c);
        $display("test lock done");
    endtask : t_lock
    initial begin
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        t_basic();
        t_chips();
        t_lock();
        wrap_up();
    end
endmodule : snts_bench
